// ===== rms_params.svh
`ifndef RMS_PARAMS_SVH
`define RMS_PARAMS_SVH
// ----------------------------------------------------------------------
// Header and word layout
// ----------------------------------------------------------------------
`define RMS_BYTE_W        8
`define RMS_ADDR_W        6
`define RMS_WORD_W        16
`define RMS_REG_N         64
`define RMS_HDR_RD_BIT    7
`define RMS_BIT_LAST      3'h7
// ----------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------
`define RMS_ADDR_CLOCK_OUTPUT_PIN     6'h0a
`define RMS_ADDR_RF       6'h0b
`define RMS_ADDR_STAT     6'h0c
`define RMS_TRIM_HI       15
`define RMS_TRIM_LO       8
`define RMS_CSEL_HI       2
`define RMS_CSEL_LO       0
`define RMS_CSEL_UNDIV    3'h0
`define RMS_RF_EXT        0
`define RMS_RF_INV        1
`define RMS_REG_RST       16'h0000
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RMS_SYS_HZ        50000000
`define RMS_SCLK_MAX_HZ   8000000
`define RMS_SCLK_HALF_CYC ((`RMS_SYS_HZ + 2 * `RMS_SCLK_MAX_HZ - 1) / (2 * `RMS_SCLK_MAX_HZ))
`define RMS_SYNC_MARGIN   2
`define RMS_DIV_W         7
`endif

// ===== rms_pkg.sv
`default_nettype none
`include "rms_params.svh"
package rms_pkg;
  // Host sequencer states, Gray coded along the path except the return from HS_GAP to HS_IDLE.
  typedef enum logic [2:0] {
    HS_IDLE  = 3'b000,
    HS_SEL   = 3'b001,
    HS_SHIFT = 3'b011,
    HS_END   = 3'b010,
    HS_GAP   = 3'b110
  } rms_host_st_e;
  typedef logic [`RMS_ADDR_W-1:0] rms_addr_t;
  typedef logic [`RMS_WORD_W-1:0] rms_word_t;
  typedef logic [`RMS_BYTE_W-1:0] rms_byte_t;
endpackage
`default_nettype wire

// ===== rms_spi_if.sv
`default_nettype none
interface rms_spi_if;
  logic serial_link_clock;  // Driven by the host only.
  logic ce_n;               // Transaction select, active low.
  logic mosi;               // Host to device data.
  logic miso;               // Device to host data.
  logic miso_oe_n;          // Low while the device drives miso.
  logic miso_wire;          // Resolved line level, pulled low when undriven.
  assign miso_wire = miso_oe_n ? 1'b0 : miso;
  modport dev  (input serial_link_clock, ce_n, mosi, output miso, miso_oe_n);
  modport host (output serial_link_clock, ce_n, mosi, input miso_wire);
endinterface
`default_nettype wire

// ===== rms_dev.sv
`default_nettype none
`include "rms_params.svh"
module rms_dev #(
  parameter int unsigned REG_N = `RMS_REG_N
) (
  // Serial link, clocked by the host.
  rms_spi_if.dev                 spi,
  // Core clock and reset.
  input  wire logic              clk_sys_i,
  input  wire logic              rstn_i,
  // Modem state.
  input  wire logic              modem_awake_i,
  input  wire logic              tx_active_i,
  // Oscillator and radio controls.
  output logic [`RMS_BYTE_W-1:0] xtal_trim_o,
  output logic                   clock_output_pin_o,
  output logic                   antenna_switch_bias_o
);
  import rms_pkg::*;

  // ----------------------------------------------------------------------
  // Link domain: header and write capture
  // ----------------------------------------------------------------------
  logic      lnk_rst_n;   // Held in reset while select is high.
  logic [2:0] bit_q;      // Bit position inside the current burst.
  rms_byte_t sh_q;        // Incoming shift register.
  rms_byte_t in_byte;     // Burst value including the bit on this edge.
  logic      byte_done;   // This edge completes a burst.
  logic      hdr_done_q;  // Header burst has been taken.
  logic      rd_q;        // Transaction is a read.
  rms_addr_t addr_q;      // Current word address, advances per write word.
  rms_byte_t hi_q;        // First byte of a write word.
  logic      half_q;      // Next payload byte is the second of a word.
  logic      word_wr;     // A write word completes on this edge.

  assign lnk_rst_n = rstn_i & ~spi.ce_n;
  assign in_byte   = {sh_q[`RMS_BYTE_W-2:0], spi.mosi};
  assign byte_done = (bit_q == `RMS_BIT_LAST);
  assign word_wr   = byte_done & hdr_done_q & ~rd_q & half_q;

  // Input bits are taken on the rising edge, header first.
  always_ff @(posedge spi.serial_link_clock or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      bit_q      <= 3'h0;
      sh_q       <= '0;
      hdr_done_q <= 1'b0;
      rd_q       <= 1'b0;
      addr_q     <= '0;
      hi_q       <= '0;
      half_q     <= 1'b0;
    end else begin
      bit_q <= bit_q + 3'h1;
      sh_q  <= in_byte;
      if (byte_done && !hdr_done_q) begin
        // Header: direction in the top bit, address in the low bits.
        hdr_done_q <= 1'b1;
        rd_q       <= in_byte[`RMS_HDR_RD_BIT];
        addr_q     <= in_byte[`RMS_ADDR_W-1:0];
      end else if (byte_done && !rd_q) begin
        // Write payload pairs bytes into words, high byte first.
        if (!half_q) begin
          hi_q <= in_byte;
        end
        half_q <= ~half_q;
        if (half_q) begin
          addr_q <= addr_q + 6'h01;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: write hold register and toggle towards the core
  // ----------------------------------------------------------------------
  rms_addr_t wr_addr_q;   // Held address of the last write word.
  rms_word_t wr_data_q;   // Held data of the last write word.
  logic      wr_tgl_q;    // Flips once per completed write word.

  // Survives select so that the toggle never produces a false event.
  always_ff @(posedge spi.serial_link_clock or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_addr_q <= '0;
      wr_data_q <= '0;
      wr_tgl_q  <= 1'b0;
    end else if (word_wr) begin
      wr_addr_q <= addr_q;
      wr_data_q <= {hi_q, in_byte};
      wr_tgl_q  <= ~wr_tgl_q;
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: read data out on the falling edge
  // ----------------------------------------------------------------------
  logic [2:0] hcnt_q;     // Falling edges seen during the header.
  logic       pl_q;       // Payload phase has started.
  logic [3:0] ocnt_q;     // Bit position inside the outgoing word.
  rms_word_t  out_q;      // Outgoing shift register.
  rms_addr_t  rd_ptr_q;   // Address of the next word to send.
  logic       miso_q;     // Registered output bit.
  rms_addr_t  rd_sel;     // Address being loaded on this edge.
  rms_word_t  rd_word;    // Register value at rd_sel.
  logic       rd_load;    // A new word is loaded on this edge.
  logic       hdr_last;   // This falling edge follows the header.

  assign hdr_last = ~pl_q & (hcnt_q == `RMS_BIT_LAST);
  assign rd_sel   = hdr_last ? addr_q : rd_ptr_q;
  assign rd_load  = rd_q & (hdr_last | (pl_q & (ocnt_q == 4'h0)));

  // Output changes on the falling edge, most significant bit first.
  always_ff @(negedge spi.serial_link_clock or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      hcnt_q   <= 3'h0;
      pl_q     <= 1'b0;
      ocnt_q   <= 4'h0;
      out_q    <= '0;
      rd_ptr_q <= '0;
      miso_q   <= 1'b0;
    end else begin
      if (!pl_q) begin
        hcnt_q <= hcnt_q + 3'h1;
        pl_q   <= hdr_last;
      end
      if (rd_load) begin
        miso_q   <= rd_word[`RMS_WORD_W-1];
        out_q    <= {rd_word[`RMS_WORD_W-2:0], 1'b0};
        rd_ptr_q <= rd_sel + 6'h01;
        ocnt_q   <= 4'h1;
      end else if (rd_q && pl_q) begin
        miso_q <= out_q[`RMS_WORD_W-1];
        out_q  <= {out_q[`RMS_WORD_W-2:0], 1'b0};
        ocnt_q <= ocnt_q + 4'h1;
      end
    end
  end

  // Line driven only in a read payload; header and writes leave it free.
  assign spi.miso      = miso_q;
  assign spi.miso_oe_n = ~(pl_q & rd_q & ~spi.ce_n);

  // ----------------------------------------------------------------------
  // Core domain: write event synchroniser
  // ----------------------------------------------------------------------
  logic wr_s1_q;          // First stage, read only by the second.
  logic wr_s2_q;          // Second stage.
  logic wr_s3_q;          // Third stage.
  logic wr_f_q;           // Filtered toggle level.
  logic wr_agree;         // Second and third stages agree.
  logic wr_ev;            // One core cycle per write word.

  assign wr_agree = (wr_s2_q == wr_s3_q);
  assign wr_ev    = wr_agree & (wr_s3_q != wr_f_q);

  // Brings the write toggle onto the core clock.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_s1_q <= 1'b0;
      wr_s2_q <= 1'b0;
      wr_s3_q <= 1'b0;
      wr_f_q  <= 1'b0;
    end else begin
      wr_s1_q <= wr_tgl_q;
      wr_s2_q <= wr_s1_q;
      wr_s3_q <= wr_s2_q;
      if (wr_agree) begin
        wr_f_q <= wr_s3_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Core domain: register file
  // ----------------------------------------------------------------------
  rms_word_t regs_q [REG_N];  // Resource registers by address.
  logic      wr_ok;           // Write accepted by the core.

  // Writes land only while the modem is awake; status is read-only.
  assign wr_ok = wr_ev & modem_awake_i & (wr_addr_q != `RMS_ADDR_STAT);

  // Moves held words into registers on the core clock.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < REG_N; i++) begin
        regs_q[i] <= `RMS_REG_RST;
      end
    end else if (wr_ok) begin
      regs_q[wr_addr_q] <= wr_data_q;
    end
  end

  // Read mux. Registers change a few core cycles after each accepted write word completes,
  // so a later read sees them settled; asleep the port returns zero.
  assign rd_word = !modem_awake_i ? '0 :
                   (rd_sel == `RMS_ADDR_STAT) ?
                   {14'h0000, tx_active_i, modem_awake_i} : regs_q[rd_sel];

  // ----------------------------------------------------------------------
  // Oscillator controls
  // ----------------------------------------------------------------------
  logic [`RMS_DIV_W-1:0] div_q;   // Free-running reference divider.
  logic [2:0]            csel;    // Clock output select field.

  assign xtal_trim_o = regs_q[`RMS_ADDR_CLOCK_OUTPUT_PIN][`RMS_TRIM_HI:`RMS_TRIM_LO];
  assign csel        = regs_q[`RMS_ADDR_CLOCK_OUTPUT_PIN][`RMS_CSEL_HI:`RMS_CSEL_LO];

  // Divider gives the slower clock output choices.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  // Select zero passes the reference through; others pick a divider tap.
  assign clock_output_pin_o = (csel == `RMS_CSEL_UNDIV) ? clk_sys_i :
                              div_q[csel - 3'h1];

  // ----------------------------------------------------------------------
  // Antenna switch bias
  // ----------------------------------------------------------------------
  logic ext_sw;           // External switch mode.
  logic bias_inv;         // Inverted polarity in external mode.
  logic bias_q;           // Registered bias level.

  assign ext_sw   = regs_q[`RMS_ADDR_RF][`RMS_RF_EXT];
  assign bias_inv = regs_q[`RMS_ADDR_RF][`RMS_RF_INV];

  // High on transmit, low on receive, flipped only for an external switch.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bias_q <= 1'b0;
    end else begin
      bias_q <= tx_active_i ^ (ext_sw & bias_inv);
    end
  end

  assign antenna_switch_bias_o = bias_q;

endmodule
`default_nettype wire

// ===== rms_host.sv
`default_nettype none
`include "rms_params.svh"
module rms_host #(
  parameter int unsigned HALF_CYC = `RMS_SCLK_HALF_CYC + `RMS_SYNC_MARGIN
) (
  // System clock and reset.
  input  wire logic             clk_sys_i,
  input  wire logic             rstn_i,
  // Serial link.
  rms_spi_if.host               spi,
  // Request.
  input  wire logic             start_i,
  input  wire logic             rd_i,
  input  wire rms_pkg::rms_addr_t addr_i,
  input  wire logic [3:0]       words_i,
  input  wire rms_pkg::rms_word_t wdata_i,
  // Answer.
  output logic                  busy_o,
  output logic                  wdata_take_o,
  output rms_pkg::rms_word_t    rdata_o,
  output logic                  rdata_valid_o,
  output logic                  done_o
);
  import rms_pkg::*;

  // ----------------------------------------------------------------------
  // Return line filter
  // ----------------------------------------------------------------------
  logic m1_q, m2_q, m3_q, mf_q; // Three stages and filtered level.

  // Master-in is filtered; the clock half period covers its latency.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      m1_q <= 1'b0;
      m2_q <= 1'b0;
      m3_q <= 1'b0;
      mf_q <= 1'b0;
    end else begin
      m1_q <= spi.miso_wire;
      m2_q <= m1_q;
      m3_q <= m2_q;
      if (m2_q == m3_q) begin
        mf_q <= m3_q;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  rms_host_st_e st_q;       // Sequencer state.
  logic [7:0]   ph_q;       // Half period counter.
  logic [2:0]   bit_q;      // Bit inside the burst.
  logic [4:0]   left_q;     // Payload bytes still to send.
  logic         pay_q;      // Payload phase.
  logic         lo_nxt_q;   // Next payload byte is a low byte.
  logic         rd_q;       // Read transaction.
  rms_byte_t    so_q;       // Outgoing shift register.
  rms_byte_t    lo_q;       // Saved low byte of the write word.
  rms_word_t    si_q;       // Incoming shift register.
  logic         sclk_q, ce_n_q, mosi_q, take_q, rv_q, done_q;
  logic         ph_end;     // Half period elapsed.
  logic [3:0]   nw;         // Word count, at least one.
  rms_byte_t    nxt;        // Next byte to send.

  assign ph_end = (ph_q == 8'(HALF_CYC - 1));
  assign nw     = (words_i == 4'h0) ? 4'h1 : words_i;
  assign nxt    = lo_nxt_q ? lo_q : (rd_q ? 8'h00 : wdata_i[15:8]);

  // Drives select, clock and data; samples on the rising edge.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q     <= HS_IDLE;
      ph_q     <= '0;
      bit_q    <= '0;
      left_q   <= '0;
      pay_q    <= 1'b0;
      lo_nxt_q <= 1'b0;
      rd_q     <= 1'b0;
      so_q     <= '0;
      lo_q     <= '0;
      si_q     <= '0;
      sclk_q   <= 1'b0;
      ce_n_q   <= 1'b1;
      mosi_q   <= 1'b0;
      take_q   <= 1'b0;
      rv_q     <= 1'b0;
      done_q   <= 1'b0;
      rdata_o <= '0;
    end else begin
      take_q <= 1'b0;
      rv_q   <= 1'b0;
      done_q <= 1'b0;
      ph_q   <= ph_end ? 8'h00 : ph_q + 8'h01;
      case (st_q)
        HS_IDLE: begin
          ph_q <= '0;
          if (start_i) begin
            // Header: direction on top, address below.
            rd_q   <= rd_i;
            so_q   <= {rd_i, 1'b0, addr_i};
            mosi_q <= rd_i;
            left_q <= {nw, 1'b0};
            pay_q    <= 1'b0;
            lo_nxt_q <= 1'b0;
            bit_q    <= '0;
            ce_n_q <= 1'b0;
            st_q   <= HS_SEL;
          end
        end
        HS_SEL:   if (ph_end) st_q <= HS_SHIFT;
        HS_SHIFT: if (ph_end) begin
          sclk_q <= ~sclk_q;
          if (!sclk_q) begin
            si_q <= {si_q[14:0], mf_q};
          end else if (bit_q != `RMS_BIT_LAST) begin
            bit_q  <= bit_q + 3'h1;
            so_q   <= {so_q[6:0], 1'b0};
            mosi_q <= so_q[6];
          end else begin
            bit_q <= '0;
            if (pay_q && lo_nxt_q == 1'b0 && rd_q) begin
              rdata_o <= si_q;
              rv_q    <= 1'b1;
            end
            if (left_q == 5'h00) begin
              st_q <= HS_END;
            end else begin
              pay_q    <= 1'b1;
              so_q     <= nxt;
              mosi_q   <= nxt[7];
              lo_nxt_q <= ~lo_nxt_q;
              left_q   <= left_q - 5'h01;
              if (!lo_nxt_q) begin
                lo_q   <= wdata_i[7:0];
                take_q <= ~rd_q;
              end
            end
          end
        end
        HS_END: if (ph_end) begin
          ce_n_q <= 1'b1;
          st_q   <= HS_GAP;
        end
        HS_GAP: if (ph_end) begin
          done_q <= 1'b1;
          st_q   <= HS_IDLE;
        end
        default: st_q <= HS_IDLE;
      endcase
    end
  end

  assign spi.serial_link_clock = sclk_q;
  assign spi.ce_n              = ce_n_q;
  assign spi.mosi              = mosi_q;
  assign busy_o                = (st_q != HS_IDLE);
  assign wdata_take_o          = take_q;
  assign rdata_valid_o         = rv_q;
  assign done_o                = done_q;

endmodule
`default_nettype wire

// ===== rms_spi_props.sv
`default_nettype none
module rms_spi_props (
  // Core clock and reset.
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // Link signals.
  input wire logic serial_link_clock,
  input wire logic ce_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe_n,
  input wire logic miso_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Frame tracking
  // ----------------------------------------------------------------------
  logic [8:0] edges_q;  // Rising link edges seen in the current frame.
  logic [8:0] edges_d;  // Next edge count.
  logic       rd_q;     // Direction bit taken from the header.
  logic       rd_d;     // Next direction bit.
  logic       sclk_q;   // Link clock one core cycle ago.
  wire        rise_w;   // Link clock rose since the last core edge.
  assign rise_w  = serial_link_clock & ~sclk_q;
  assign edges_d = ce_n ? 9'h000 : edges_q + {8'h00, rise_w};
  assign rd_d    = (rise_w && edges_q == 9'h000) ? mosi : rd_q;
  // The counters restart whenever the select is high.
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      edges_q <= 9'h000;
      rd_q    <= 1'b0;
      sclk_q  <= 1'b0;
    end else begin
      edges_q <= edges_d;
      rd_q    <= rd_d;
      sclk_q  <= serial_link_clock;
    end
  end
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rstn_i);
  a_clk_idle_low: assert property (ce_n |-> !serial_link_clock)
    else $error("link clock high outside a frame");
  a_sel_lead_gap: assert property ($fell(ce_n) |-> !serial_link_clock [*4])
    else $error("link clock moved too soon after select fell");
  a_mosi_on_fall: assert property (!ce_n && $past(!ce_n) && $changed(mosi)
    |-> $fell(serial_link_clock)) else $error("host data moved off a falling edge");
  a_miso_on_fall: assert property (!miso_oe_n && $past(!miso_oe_n) && $changed(miso)
    |-> !serial_link_clock) else $error("device data moved while clock high");
  a_clk_high_min: assert property ($rose(serial_link_clock) |=> serial_link_clock [*3])
    else $error("link clock high phase too short");
  a_clk_low_min: assert property ($fell(serial_link_clock) && !ce_n
    |=> !serial_link_clock [*3]) else $error("link clock low phase too short");
  a_one_dir_read: assert property (!miso_oe_n |-> !ce_n && rd_q && edges_q >= 9'd8)
    else $error("device drove data outside a read payload");
  a_frame_length: assert property ($rose(ce_n)
    |-> edges_q >= 9'd24 && edges_q[3:0] == 4'h8) else $error("frame length wrong");
  // Main scenarios seen.
  c_read_frame: cover property ($rose(ce_n) && rd_q);
  c_write_frame: cover property ($rose(ce_n) && !rd_q);
  c_long_frame: cover property ($rose(ce_n) && edges_q >= 9'd40);
endmodule
`default_nettype wire

// ===== tb.sv
`default_nettype none
`include "rms_params.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rms_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic       clk_sys_i = 1'b0;  // Core clock.
  logic       rstn_i    = 1'b0;  // Reset, active low.
  logic       start_i   = 1'b0;  // Host request inputs.
  logic       rd_i      = 1'b0;
  rms_addr_t  addr_i    = '0;
  logic [3:0] words_i   = 4'h1;
  rms_word_t  wdata_i   = '0;
  logic       awake_i   = 1'b1;  // Modem state inputs.
  logic       tx_i      = 1'b0;
  logic       busy_o, take_o, rvalid_o, done_o, cko_o, bias_o;
  rms_word_t  rdata_o;
  rms_byte_t  trim_o;
  rms_word_t  mem [64];          // Expected register contents.
  rms_word_t  wq[$];             // Words to send.
  rms_word_t  rq[$];             // Words received.
  int         n_fail = 0;
  int         n_checks = 0;
  always #10 clk_sys_i = ~clk_sys_i;
  // ----------------------------------------------------------------------
  // Both ends joined by the link
  // ----------------------------------------------------------------------
  rms_spi_if i_rms_spi_if ();
  rms_host i_rms_host (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .spi(i_rms_spi_if),
    .start_i(start_i), .rd_i(rd_i), .addr_i(addr_i), .words_i(words_i), .wdata_i(wdata_i),
    .busy_o(busy_o), .wdata_take_o(take_o), .rdata_o(rdata_o), .rdata_valid_o(rvalid_o),
    .done_o(done_o));
  rms_dev i_rms_dev (.spi(i_rms_spi_if), .clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .modem_awake_i(awake_i), .tx_active_i(tx_i), .xtal_trim_o(trim_o),
    .clock_output_pin_o(cko_o), .antenna_switch_bias_o(bias_o));
  rms_spi_props i_rms_spi_props (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .serial_link_clock(i_rms_spi_if.serial_link_clock), .ce_n(i_rms_spi_if.ce_n),
    .mosi(i_rms_spi_if.mosi), .miso(i_rms_spi_if.miso),
    .miso_oe_n(i_rms_spi_if.miso_oe_n), .miso_wire(i_rms_spi_if.miso_wire));
  // ----------------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------------
  task automatic chk_word(input rms_word_t got, input rms_word_t exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // What a read should return: dead port gives zero, status shows the inputs.
  function automatic rms_word_t exp_rd(input rms_addr_t a);
    if (!awake_i) return '0;
    if (a == `RMS_ADDR_STAT) return {14'h0000, tx_i, awake_i};
    return mem[a];
  endfunction
  // ----------------------------------------------------------------------
  // Host request driver
  // ----------------------------------------------------------------------
  // One frame; write words come from wq, read words land in rq.
  task automatic xfer(input logic rd, input rms_addr_t a, input int n);
    int  k;
    int  c;
    int  nt;
    logic adv;
    k = 0;
    nt = 0;
    adv = 1'b0;
    rq = {};
    rd_i = rd;
    addr_i = a;
    words_i = 4'(n);
    wdata_i = rd ? '0 : wq[0];
    start_i = 1'b1;
    for (c = 0; c < 3000; c++) begin
      @(posedge clk_sys_i);
      #1;
      start_i = 1'b0;
      if (adv && k + 1 < wq.size()) begin
        k++;
        wdata_i = wq[k];
      end
      adv = take_o;
      if (take_o === 1'b1) nt++;
      if (rvalid_o === 1'b1) rq.push_back(rdata_o);
      if (c == 0) chk_bit(busy_o, 1'b1);
      if (done_o === 1'b1) begin
        chk_bit(busy_o, 1'b0);
        break;
      end
    end
    chk_bit(c < 3000, 1'b1);
    chk_word(16'(nt), rd ? 16'h0000 : 16'(n));
  endtask
  // Writes wq from a and keeps the expected copy up to date.
  task automatic wr(input rms_addr_t a);
    xfer(1'b0, a, wq.size());
    foreach (wq[i])
      if (awake_i && rms_addr_t'(a + i) != `RMS_ADDR_STAT) mem[rms_addr_t'(a + i)] = wq[i];
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic rdchk(input rms_addr_t a, input int n);
    xfer(1'b1, a, n);
    chk_word(16'(rq.size()), 16'(n));
    for (int i = 0; i < n; i++) chk_word(rq[i], exp_rd(rms_addr_t'(a + i)));
  endtask
  // Clock output must follow the core clock in both phases.
  task automatic chk_cko();
    repeat (3) begin
      @(posedge clk_sys_i);
      #2 chk_bit(cko_o, 1'b1);
      @(negedge clk_sys_i);
      #2 chk_bit(cko_o, 1'b0);
    end
    // Hand back just after a rising edge, where all stimulus changes.
    @(posedge clk_sys_i);
    #1;
  endtask
  // Select one gives the reference halved: a new level every core cycle.
  task automatic chk_half();
    logic p;
    @(posedge clk_sys_i);
    #2 p = cko_o;
    repeat (3) begin
      @(posedge clk_sys_i);
      #2 chk_bit(cko_o, ~p);
      p = cko_o;
    end
    @(posedge clk_sys_i);
    #1;
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rms_word_t w;
    rms_addr_t a;
    foreach (mem[i]) mem[i] = '0;
    void'($urandom(27933));
    repeat (10) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    chk_word({8'h00, trim_o}, 16'h0000);
    chk_bit(bias_o, 1'b0);
    chk_cko();
    rdchk(`RMS_ADDR_CLOCK_OUTPUT_PIN, 2);
    // Warp code and undivided clock select, then the switch register.
    w = rms_word_t'($urandom) & 16'hfff8;
    wq = {w, 16'h0000};
    wr(`RMS_ADDR_CLOCK_OUTPUT_PIN);
    chk_word({8'h00, trim_o}, {8'h00, w[15:8]});
    chk_cko();
    rdchk(`RMS_ADDR_CLOCK_OUTPUT_PIN, 2);
    // A divided select must leave the pass-through path.
    wq = {w | 16'h0001};
    wr(`RMS_ADDR_CLOCK_OUTPUT_PIN);
    chk_half();
    for (int v = 0; v < 4; v++) begin
      wq = {16'(v)};
      wr(`RMS_ADDR_RF);
      for (int t = 0; t < 2; t++) begin
        tx_i = t[0];
        repeat (3) @(posedge clk_sys_i);
        #1 chk_bit(bias_o, t[0] ^ (v[0] & v[1]));
      end
    end
    // Random multi-word traffic, back to back, plus the read-only status.
    for (int j = 0; j < 6; j++) begin
      a = rms_addr_t'(6'h10 + $urandom_range(0, 31));
      wq = {};
      repeat ($urandom_range(1, 3)) wq.push_back(rms_word_t'($urandom));
      wr(a);
      rdchk(a, wq.size());
    end
    wq = {16'hffff};
    wr(`RMS_ADDR_STAT);
    rdchk(`RMS_ADDR_STAT, 1);
    // Sleeping modem: writes are lost and reads give zero.
    awake_i = 1'b0;
    wq = {16'h5a5a};
    wr(6'h20);
    rdchk(6'h20, 1);
    awake_i = 1'b1;
    rdchk(6'h20, 1);
    close_out();
  end
  // Cut a hang short well beyond the expected run length.
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    n_fail++;
    close_out();
  end
endmodule
`default_nettype wire
